/* fpic_unit.sv */
// Purpose: float/integer and single/double conversion stage of the core
// Assumes: one request per clock from issue; result one cycle later
// Notes: exception flags accumulate in the status word; no traps here
`timescale 1ns/100ps
`include "fpic_consts.svh"
module fpic_unit import fpic_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // issue side
  input wire logic req_valid,
  input wire fpic_req_t req,
  // status word
  input wire logic [1:0] fp_round_mode,
  input wire logic fp_status_clear,
  output fpic_flags_t fp_status_word,
  // writeback side
  output logic rsp_valid,
  output fpic_rsp_t rsp
);
  // ---------------------------------------------------------------
  // arithmetic helpers
  // ---------------------------------------------------------------
  function automatic logic [6:0] lead_zeros(input logic [63:0] v);
    lead_zeros = 7'h40;
    for (int i = 0; i < 64; i++) if (v[i]) lead_zeros = 7'(63 - i);
  endfunction : lead_zeros

  // shared by float packing and integer conversion
  function automatic logic round_up(input logic [1:0] rm, input logic sign,
                                    input logic lsb, input logic g, input logic s);
    case (rm)
      `FPIC_RC_NEAR: round_up = g & (s | lsb);
      `FPIC_RC_DOWN: round_up = sign & (g | s);
      `FPIC_RC_UP: round_up = !sign & (g | s);
      default: round_up = 1'b0;
    endcase
  endfunction : round_up

  // any source to sign, unbiased exponent and mantissa with its top bit at 63
  function automatic fpic_num_t unpack(input fpic_kind_t k, input logic [63:0] x);
    logic [63:0] mag;
    logic [10:0] e;
    logic [63:0] f;
    logic dbl;
    logic [6:0] lz;
    logic signed [12:0] base;
    unpack = '0;
    mag = '0;
    e = '0;
    f = '0;
    dbl = (k == k_double);
    case (k)
      k_int32: begin
        unpack.sign = x[31];
        mag = {32'h0, x[31] ? (~x[31:0] + 32'h1) : x[31:0]};
      end
      k_int64: begin
        unpack.sign = x[63];
        mag = x[63] ? (~x + 64'h1) : x;
      end
      default: begin
        e = dbl ? x[62:52] : {3'h0, x[30:23]};
        f = dbl ? {x[51:0], 12'h0} : {x[22:0], 41'h0};
        unpack.sign = dbl ? x[63] : x[31];
        unpack.inf = (64'(e) == (dbl ? `FPIC_DBL_EMAX : `FPIC_SGL_EMAX)) && f == '0;
        unpack.nan = (64'(e) == (dbl ? `FPIC_DBL_EMAX : `FPIC_SGL_EMAX)) && f != '0;
        unpack.snan = unpack.nan && !f[63];
        mag = {e != 11'h0, f[63:1]};
      end
    endcase
    lz = lead_zeros(mag);
    base = (k == k_int32 || k == k_int64) ? 13'sh03f :
           $signed({2'h0, (e == 11'h0) ? 11'h1 : e}) - (dbl ? `FPIC_DBL_BIAS : `FPIC_SGL_BIAS);
    unpack.exp = base - $signed({6'h0, lz});
    unpack.mant = mag << lz;
    unpack.zero = (mag == '0);
  endfunction : unpack

  // round and pack to single (low word) or double
  function automatic fpic_lane_t pack(input logic dbl, input fpic_num_t n, input logic [1:0] rm);
    logic signed [12:0] be;
    logic signed [12:0] t;
    logic [127:0] wide;
    logic up;
    logic [5:0] fw;
    logic [63:0] field;
    logic [63:0] emaxf;
    pack = '0;
    fw = dbl ? `FPIC_DBL_FRAC : `FPIC_SGL_FRAC;
    emaxf = (dbl ? `FPIC_DBL_EMAX : `FPIC_SGL_EMAX) << fw;
    be = n.exp + (dbl ? `FPIC_DBL_BIAS : `FPIC_SGL_BIAS);
    // tiny values shift further right so the field lands as a denormal
    t = (dbl ? 13'sh00b : 13'sh028) + ((be <= 13'sh000) ? (13'sh001 - be) : 13'sh000);
    wide = {n.mant, 64'h0} >> ((t > 13'sh07f) ? 7'h7f : t[6:0]);
    up = round_up(rm, n.sign, wide[64], wide[63], |wide[62:0]);
    // adding the rounded mantissa onto exponent-1 lets the carry bump the exponent
    field = ((be <= 13'sh000) ? 64'h0 : (64'(be - 13'sh001) << fw)) + wide[127:64] + 64'(up);
    pack.flags.inx = wide[63] | (|wide[62:0]);
    pack.flags.unf = (be <= 13'sh000) && pack.flags.inx;
    if (field >= emaxf) begin
      pack.flags.ovf = 1'b1;
      pack.flags.inx = 1'b1;
      field = (rm == `FPIC_RC_NEAR || (rm == `FPIC_RC_UP && !n.sign) ||
               (rm == `FPIC_RC_DOWN && n.sign)) ? emaxf : emaxf - 64'h1;
    end
    if (n.nan || n.inf || n.zero) begin
      pack.flags = '0;
      pack.flags.inv = n.snan;
      field = n.zero ? 64'h0 : emaxf;
      if (n.nan) field = dbl ? {1'b0, 11'h7ff, 1'b1, n.mant[61:11]} :
                               {33'h0, 8'hff, 1'b1, n.mant[61:40]};
    end
    pack.value = dbl ? {n.sign, field[62:0]} : {32'h0, n.sign, field[30:0]};
  endfunction : pack

  // round to a signed integer; out of range and NaN give the indefinite value
  function automatic fpic_lane_t to_int(input logic is64, input fpic_num_t n,
                                        input logic [1:0] rm);
    logic signed [12:0] t;
    logic [127:0] wide;
    logic [64:0] m;
    logic [64:0] limit;
    to_int = '0;
    t = 13'sh03f - n.exp;
    wide = {n.mant, 64'h0} >> ((t > 13'sh07f) ? 7'h7f : t[6:0]);
    m = {1'b0, wide[127:64]} + 65'(round_up(rm, n.sign, wide[64], wide[63], |wide[62:0]));
    limit = is64 ? {2'h1, 63'h0} : 65'h0_8000_0000;
    to_int.flags.inx = wide[63] | (|wide[62:0]);
    to_int.value = n.sign ? (~m[63:0] + 64'h1) : m[63:0];
    if (!is64) to_int.value = {32'h0, to_int.value[31:0]};
    if (n.nan || n.inf || n.exp > 13'sh03f || (n.sign ? m > limit : m >= limit)) begin
      to_int.flags = '0;
      to_int.flags.inv = 1'b1;
      to_int.value = is64 ? `FPIC_INDEF64 : `FPIC_INDEF32;
    end
  endfunction : to_int

  function automatic fpic_lane_t convert(input fpic_route_t r, input logic [63:0] x,
                                         input logic [1:0] rm, input logic trunc);
    fpic_num_t n;
    n = unpack(r.src, x);
    if (r.dst == k_single || r.dst == k_double) convert = pack(r.dst == k_double, n, rm);
    else convert = to_int(r.dst == k_int64, n, trunc ? `FPIC_RC_ZERO : rm);
  endfunction : convert

  // ---------------------------------------------------------------
  // operation decode
  // ---------------------------------------------------------------
  function automatic fpic_route_t decode(input fpic_op_t op);
    case (op)
      int32_to_single_insert: decode = '{k_int32, k_single, pick_second, shape_insert};
      int32_to_single_packed: decode = '{k_int32, k_single, pick_second, shape_packed};
      int32_to_double_low: decode = '{k_int32, k_double, pick_second, shape_whole};
      int32_to_double_high: decode = '{k_int32, k_double, pick_second_high, shape_whole};
      int64_to_single_insert: decode = '{k_int64, k_single, pick_second, shape_insert};
      int64_to_double: decode = '{k_int64, k_double, pick_first, shape_whole};
      single_to_int32: decode = '{k_single, k_int32, pick_first, shape_whole};
      single_to_int32_packed: decode = '{k_single, k_int32, pick_first, shape_packed};
      single_to_int64: decode = '{k_single, k_int64, pick_first, shape_whole};
      double_to_int32: decode = '{k_double, k_int32, pick_first, shape_whole};
      double_to_int32_packed: decode = '{k_double, k_int32, pick_second, shape_packed};
      double_to_int64: decode = '{k_double, k_int64, pick_first, shape_whole};
      double_to_single_insert: decode = '{k_double, k_single, pick_second, shape_insert};
      double_to_single_packed: decode = '{k_double, k_single, pick_second, shape_packed};
      single_to_double_low: decode = '{k_single, k_double, pick_second, shape_whole};
      default: decode = '{k_single, k_double, pick_second_high, shape_whole};
    endcase
  endfunction : decode

  // ---------------------------------------------------------------
  // lanes: lane 0 is the low word, lane 1 only serves packed forms
  // ---------------------------------------------------------------
  fpic_route_t route;
  logic [63:0] lane_x [2];
  fpic_lane_t lane_out [2];
  logic trunc;
  fpic_flags_t next_flags;
  logic [63:0] next_value;

  assign route = decode(req.op);
  assign trunc = req.size[`FPIC_SIZE_TRUNC_BIT]; // only float-to-int reads it
  // the high lane of packed forms: doubles from the first source, int32 from the second
  assign lane_x[1] = (route.src == k_double) ? req.first_source :
                     {32'h0, (route.src == k_int32) ? req.second_source[63:32] :
                                                      req.first_source[63:32]};
  // low lane source picks the half that the widening variant names
  assign lane_x[0] = (route.pick == pick_first) ? req.first_source :
                     (route.pick == pick_second_high) ? {32'h0, req.second_source[63:32]} :
                     req.second_source;

  for (genvar i = 0; i < 2; i++) begin : g_lane
    assign lane_out[i] = convert(route, lane_x[i], fp_round_mode, trunc);
  end

  // result shaping: insert keeps the first source's high half
  assign next_value = (route.shape == shape_insert) ?
                      {req.first_source[63:32], lane_out[0].value[31:0]} :
                      (route.shape == shape_packed) ?
                      {lane_out[1].value[31:0], lane_out[0].value[31:0]} :
                      lane_out[0].value;
  assign next_flags = lane_out[0].flags | ((route.shape == shape_packed) ? lane_out[1].flags : '0);

  // ---------------------------------------------------------------
  // writeback register and status word
  // ---------------------------------------------------------------
  // valid and data are both reset; data loads every cycle, so valid says which results are live
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rsp_valid <= 1'b0;
      rsp <= '0;
    end else begin
      rsp_valid <= req_valid;
      rsp.value <= next_value;
      rsp.invalid_result_tag <= req_valid && req.trap && next_flags != '0;
    end
  end

  // a new exception in the clearing cycle survives the clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) fp_status_word <= '0;
    else fp_status_word <= (fp_status_clear ? '0 : fp_status_word) |
                           (req_valid ? next_flags : '0);
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic go;
  assign go = req_valid;

  AST_LATENCY: assert property (go |=> rsp_valid ##1 ($past(go) == rsp_valid))
    else $error("result valid not one cycle after issue");
  AST_INT32_EXACT: assert property (go && req.op == int32_to_double_low && !req.trap
    |=> rsp.value[62:0] != 63'h0 || $past(req.second_source[31:0]) == 32'h0)
    else $error("int32 to double lost a nonzero value");
  AST_INSERT_KEEP: assert property (go && route.shape == shape_insert
    |=> rsp.value[63:32] == $past(req.first_source[63:32]))
    else $error("insert changed the high half");
  AST_PACKED_HIGH: assert property (go && req.op == int32_to_single_packed
    && req.second_source[63:32] == 32'h0 |=> rsp.value[63:32] == 32'h0)
    else $error("packed high lane wrong");
  AST_INT64_ONE: assert property (go && req.op == int64_to_double
    && req.first_source == 64'h1 |=> rsp.value == `FPIC_DBL_ONE)
    else $error("int64 one not converted");
  AST_TRUNC: assert property (go && req.op == single_to_int32 && req.size[0]
    && req.first_source[31:0] == 32'h3fc0_0000 |=> rsp.value == 64'h1)
    else $error("truncation not toward zero");
  AST_NAN_INDEF: assert property (go && req.op == single_to_int64
    && req.first_source[30:23] == 8'hff && req.first_source[22:0] != 23'h0
    |=> rsp.value == `FPIC_INDEF64 && fp_status_word.inv)
    else $error("nan did not give the indefinite integer");
  AST_RANGE: assert property (go && req.op == double_to_int32
    && req.first_source == 64'h41e0_0000_0000_0000 |=> rsp.value == `FPIC_INDEF32)
    else $error("out of range double not refused");
  AST_WIDEN: assert property (go && req.op == single_to_double_high
    && req.second_source[63:32] == `FPIC_SGL_ONE |=> rsp.value == `FPIC_DBL_ONE)
    else $error("high half widening wrong");
  AST_TAG_FLAGS: assert property (rsp.invalid_result_tag |-> fp_status_word != '0)
    else $error("tagged result without status flags");
  AST_D2S_LOW: assert property (go && req.op == double_to_single_packed
    && req.second_source == 64'h0 |=> rsp.value[31:0] == 32'h0)
    else $error("packed narrowing low lane wrong");

  COV_PACKED: cover property (go && route.shape == shape_packed);
  COV_INSERT: cover property (go && route.shape == shape_insert);
  COV_TAG: cover property (rsp_valid && rsp.invalid_result_tag);
  COV_CLEAR_SET: cover property (fp_status_clear && go && next_flags != '0);
endmodule : fpic_unit

/* fpic_consts.svh */
// Purpose: constants of the float/integer conversion unit
// Assumes: included by bare name wherever the values are needed
// Notes: definitions only
`ifndef FPIC_CONSTS_SVH
`define FPIC_CONSTS_SVH
// ---------------------------------------------------------------
// rounding control encoding of the status word
// ---------------------------------------------------------------
`define FPIC_RC_NEAR 2'h0
`define FPIC_RC_DOWN 2'h1
`define FPIC_RC_UP 2'h2
`define FPIC_RC_ZERO 2'h3
// ---------------------------------------------------------------
// size field, formats, special results, latency
// ---------------------------------------------------------------
`define FPIC_SIZE_TRUNC_BIT 0
`define FPIC_SGL_BIAS 13'sh07f
`define FPIC_DBL_BIAS 13'sh3ff
`define FPIC_SGL_FRAC 6'h17
`define FPIC_DBL_FRAC 6'h34
`define FPIC_SGL_EMAX 64'h0000_0000_0000_00ff
`define FPIC_DBL_EMAX 64'h0000_0000_0000_07ff
`define FPIC_INDEF32 64'h0000_0000_8000_0000
`define FPIC_INDEF64 64'h8000_0000_0000_0000
`define FPIC_DBL_ONE 64'h3ff0_0000_0000_0000
`define FPIC_SGL_ONE 32'h3f80_0000
`define FPIC_LATENCY 1
`endif

/* fpic_pkg.sv */
// Purpose: types of the float/integer conversion unit
// Assumes: nothing beyond the tool's package support
// Notes: operations carry the names used by issue and writeback
package fpic_pkg;
  // ---------------------------------------------------------------
  // operations and decode
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    int32_to_single_insert, int32_to_single_packed, int32_to_double_low,
    int32_to_double_high, int64_to_single_insert, int64_to_double,
    single_to_int32, single_to_int32_packed, single_to_int64,
    double_to_int32, double_to_int32_packed, double_to_int64,
    double_to_single_insert, double_to_single_packed,
    single_to_double_low, single_to_double_high
  } fpic_op_t;
  typedef enum logic [1:0] {k_int32, k_int64, k_single, k_double} fpic_kind_t;
  typedef enum logic [1:0] {pick_first, pick_second, pick_second_high} fpic_pick_t;
  typedef enum logic [1:0] {shape_whole, shape_insert, shape_packed} fpic_shape_t;
  typedef struct packed {
    fpic_kind_t src;
    fpic_kind_t dst;
    fpic_pick_t pick;
    fpic_shape_t shape;
  } fpic_route_t;
  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {logic inv; logic ovf; logic unf; logic inx;} fpic_flags_t;
  typedef struct packed {
    fpic_op_t op;
    logic [1:0] size;
    logic trap;
    logic [63:0] first_source;
    logic [63:0] second_source;
  } fpic_req_t;
  typedef struct packed {logic [63:0] value; logic invalid_result_tag;} fpic_rsp_t;
  typedef struct packed {logic [63:0] value; fpic_flags_t flags;} fpic_lane_t;
  typedef struct packed {
    logic sign;
    logic signed [12:0] exp;
    logic [63:0] mant;
    logic zero;
    logic inf;
    logic nan;
    logic snan;
  } fpic_num_t;
endpackage : fpic_pkg

/* fpic_wb_model.sv */
// Purpose: writeback-side partner of the conversion unit
// Assumes: writeback samples the result bus on rising edges only
// Notes: holds the last result one cycle so the bench can compare at the falling edge
`timescale 1ns/100ps
module fpic_wb_model import fpic_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // result bus from the unit
  input wire logic rsp_valid,
  input wire fpic_rsp_t rsp,
  // captured result for the bench
  output logic got,
  output fpic_rsp_t got_rsp
);
  // ---------------------------------------------------------------
  // capture
  // ---------------------------------------------------------------
  // value is taken even when not valid, the flag says whether it counts
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      got <= 1'b0;
      got_rsp <= '0;
    end else begin
      got <= rsp_valid;
      got_rsp <= rsp;
    end
  end
endmodule : fpic_wb_model

/* tb_top.sv */
// Purpose: self-checking bench of the conversion unit
// Assumes: inputs change at the falling edge, results sampled via the writeback model
// Notes: random operands stay exact so that no rounding or flags arise in that phase
`timescale 1ns/100ps
`include "fpic_consts.svh"
module tb_top;
  import fpic_pkg::*;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic clk, rst_n, req_valid, fp_status_clear, rsp_valid, got;
  logic [1:0] fp_round_mode;
  fpic_req_t req;
  fpic_flags_t fp_status_word;
  fpic_rsp_t rsp, got_rsp;
  logic [31:0] seed = 32'h4359;
  logic [1:0] iss = 2'h0;
  logic [64:0] eq[$];
  int num_errors = 0;
  int checked = 0;
  fpic_unit i_fpic_unit (.clk(clk), .rst_n(rst_n), .req_valid(req_valid), .req(req),
    .fp_round_mode(fp_round_mode), .fp_status_clear(fp_status_clear),
    .fp_status_word(fp_status_word), .rsp_valid(rsp_valid), .rsp(rsp));
  fpic_wb_model i_fpic_wb_model (.clk(clk), .rst_n(rst_n), .rsp_valid(rsp_valid), .rsp(rsp),
    .got(got), .got_rsp(got_rsp));
  always #25 clk = ~clk;
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function logic [31:0] rand32();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction : rand32
  // single results exact only for magnitudes below 2**24, which the bench keeps to; double results are exact for any int
  function automatic logic [63:0] to_float(input int n, input bit dbl);
    logic [63:0] m;
    logic [63:0] f;
    int p;
    if (n == 0) return 64'h0;
    m = 64'((n < 0) ? -n : n);
    p = 0;
    for (int i = 0; i < 32; i++) if (m[i]) p = i;
    f = dbl ? (m << (52 - p)) : (m << (23 - p));
    if (dbl) return {n < 0, 11'(p + 1023), f[51:0]};
    return {32'h0, n < 0, 8'(p + 127), f[22:0]};
  endfunction : to_float
  // f is the floor of a value that lies exactly halfway
  function automatic int round_half(input int f, input logic [1:0] rm, input logic trunc);
    if (trunc || rm == `FPIC_RC_ZERO) return (f >= 0) ? f : f + 1;
    if (rm == `FPIC_RC_DOWN) return f;
    if (rm == `FPIC_RC_UP) return f + 1;
    return (f % 2 == 0) ? f : f + 1;
  endfunction : round_half
  task automatic check(input logic [64:0] g, input logic [64:0] x, input string what);
    checked++;
    if (g !== x) begin
      num_errors++;
      $display("Error at %0t: %s got %h expected %h", $time, what, g, x);
    end
  endtask : check
  // one cycle: compare what writeback saw, then drive the next request
  task automatic step(input logic v, input fpic_req_t r, input logic [64:0] e, input logic clr,
    input logic [1:0] rm);
    @(negedge clk);
    check(65'(got), 65'(iss[1]), "result valid");
    if (got === 1'b1 && eq.size() > 0)
      check({got_rsp.invalid_result_tag, got_rsp.value}, eq.pop_front(), "result");
    iss = {iss[0], v};
    req_valid = v;
    req = r;
    fp_status_clear = clr;
    fp_round_mode = rm;
    if (v) eq.push_back(e);
  endtask : step
  task automatic idle(input int n);
    repeat (n) step(1'b0, '0, '0, 1'b0, 2'h0);
  endtask : idle
  // sources carry random filler wherever an operation must not look
  task automatic build(input fpic_op_t op, input int n1, input int n2, inout logic [63:0] a,
    inout logic [63:0] b, output logic [63:0] e);
    logic [31:0] s1, s2;
    logic [63:0] d1, d2;
    s1 = 32'(to_float(n1, 0));
    s2 = 32'(to_float(n2, 0));
    d1 = to_float(n1, 1);
    d2 = to_float(n2, 1);
    case (op)
      int32_to_single_insert: begin b[31:0] = n2; e = {a[63:32], s2}; end
      int32_to_single_packed: begin b = {n1, n2}; e = {s1, s2}; end
      int32_to_double_low: begin b[31:0] = n2; e = d2; end
      int32_to_double_high: begin b[63:32] = n1; e = d1; end
      int64_to_single_insert: begin b = 64'(n2); e = {a[63:32], s2}; end
      int64_to_double: begin a = 64'(n1); e = d1; end
      single_to_int32: begin a[31:0] = s2; e = {32'h0, n2}; end
      single_to_int32_packed: begin a = {s1, s2}; e = {n1, n2}; end
      single_to_int64: begin a[31:0] = s2; e = 64'(n2); end
      double_to_int32: begin a = d1; e = {32'h0, n1}; end
      double_to_int32_packed: begin a = d1; b = d2; e = {n1, n2}; end
      double_to_int64: begin a = d1; e = 64'(n1); end
      double_to_single_insert: begin b = d2; e = {a[63:32], s2}; end
      double_to_single_packed: begin a = d1; b = d2; e = {s1, s2}; end
      single_to_double_low: begin b[31:0] = s2; e = d2; end
      default: begin b[63:32] = s1; e = d1; end
    endcase
  endtask : build
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    logic [63:0] a, b, e;
    logic [31:0] x, y;
    fpic_req_t r;
    int res;
    clk = 1'b0;
    rst_n = 1'b0;
    req_valid = 1'b0;
    req = '0;
    fp_round_mode = 2'h0;
    fp_status_clear = 1'b0;
    r = '0;
    repeat (20) @(negedge clk);
    check(65'(rsp_valid), 65'h0, "reset valid");
    check(65'(fp_status_word), 65'h0, "reset status");
    rst_n = 1'b1;
    // every operation once, then random mix with gaps and random size and trap
    for (int i = 0; i < 300; i++) begin
      x = rand32();
      y = rand32();
      a = {rand32(), rand32()};
      b = {rand32(), rand32()};
      r.op = (i < 16) ? fpic_op_t'(i[3:0]) : fpic_op_t'(x[23:20]);
      build(r.op, int'($signed(x[19:0])), int'($signed(y[31:12])), a, b, e);
      r.size = y[1:0];
      r.trap = y[2];
      r.first_source = a;
      r.second_source = b;
      step(y[3] | (i < 16), r, {1'b0, e}, 1'b0, 2'h0);
    end
    idle(3);
    check(65'(fp_status_word), 65'h0, "exact status");
    $display("test random_exact done");
    // halfway values under every mode, truncation overriding; last clear loses to set
    for (int k = 0; k < 16; k++) begin
      x = rand32();
      res = round_half(k[0] ? -3 : 1, k[3:2], k[1]);
      r.op = x[0] ? double_to_int64 : double_to_int32;
      r.first_source = k[0] ? 64'hc004_0000_0000_0000 : 64'h3ff8_0000_0000_0000;
      r.size = {x[1], k[1]};
      r.trap = 1'b1;
      e = x[0] ? 64'(res) : {32'h0, 32'(res)};
      step(1'b1, r, {1'b1, e}, k == 15, k[3:2]);
    end
    idle(3);
    check(65'(fp_status_word), 65'h1, "inexact sticky");
    step(1'b0, r, '0, 1'b1, 2'h0);
    idle(2);
    check(65'(fp_status_word), 65'h0, "status clear");
    $display("test rounding done");
    // invalid inputs give the indefinite integer
    r.trap = 1'b1;
    r.op = double_to_int32;
    r.first_source = 64'h7ff8_0000_0000_0000;
    step(1'b1, r, {1'b1, `FPIC_INDEF32}, 1'b0, 2'h0);
    r.trap = 1'b0;
    r.op = double_to_int64;
    r.first_source = 64'h4450_0000_0000_0000;
    step(1'b1, r, {1'b0, `FPIC_INDEF64}, 1'b0, 2'h0);
    r.op = single_to_int32;
    r.first_source = 64'h1234_5678_7fc0_0000;
    step(1'b1, r, {1'b0, `FPIC_INDEF32}, 1'b0, 2'h0);
    idle(3);
    check(65'(fp_status_word), 65'h8, "invalid sticky");
    $display("test invalid done");
    // hand-picked corners: exact ones, truncation, range limits, narrowing extremes
    r.trap = 1'b0;
    r.size = 2'h1;
    r.op = int64_to_double;
    r.first_source = 64'h1;
    step(1'b1, r, {1'b0, `FPIC_DBL_ONE}, 1'b0, 2'h0);
    r.op = single_to_double_high;
    r.second_source = {`FPIC_SGL_ONE, 32'h0};
    step(1'b1, r, {1'b0, `FPIC_DBL_ONE}, 1'b0, 2'h0);
    r.op = int32_to_single_packed;
    r.second_source = 64'h1;
    step(1'b1, r, {33'h0, `FPIC_SGL_ONE}, 1'b0, 2'h0);
    r.op = single_to_int32;
    r.first_source = 64'h3fc0_0000;
    step(1'b1, r, 65'h1, 1'b0, 2'h0);
    r.op = single_to_int64;
    r.first_source = 64'h7fc0_0000;
    step(1'b1, r, {1'b0, `FPIC_INDEF64}, 1'b0, 2'h0);
    r.op = double_to_int32;
    r.first_source = 64'h41e0_0000_0000_0000;
    step(1'b1, r, {1'b0, `FPIC_INDEF32}, 1'b0, 2'h0);
    // overflow goes to infinity under nearest, a value half the least denormal goes to zero
    r.op = double_to_single_packed;
    r.first_source = 64'h47f0_0000_0000_0000;
    r.second_source = 64'h0;
    step(1'b1, r, {1'b0, 32'h7f80_0000, 32'h0}, 1'b0, 2'h0);
    r.trap = 1'b1;
    r.first_source = 64'h0;
    r.second_source = 64'h3690_0000_0000_0000;
    step(1'b1, r, {1'b1, 64'h0}, 1'b0, 2'h0);
    idle(3);
    check(65'(fp_status_word), 65'hf, "corner status");
    $display("test corners done");
    // reset in mid-run wipes the sticky word and the valid flag
    r.op = double_to_int32;
    r.first_source = 64'h3ff8_0000_0000_0000;
    step(1'b1, r, '0, 1'b0, 2'h0);
    rst_n = 1'b0;
    @(negedge clk);
    check(65'(rsp_valid), 65'h0, "mid reset valid");
    check(65'(fp_status_word), 65'h0, "mid reset status");
    req_valid = 1'b0;
    iss = 2'h0;
    eq.delete();
    rst_n = 1'b1;
    idle(3);
    $display("test mid_reset done");
    stop_test();
  end
  // cut a hang short
  initial begin
    #(100000 * 50);
    num_errors++;
    $display("Error at %0t: run limit reached", $time);
    stop_test();
  end
endmodule : tb_top
